/* rtl/alud_datapath.sv */
// Add and logical AND datapath slice with working register and status flags.

////////////////////////////////////////////////////////////////////////////////

// The datapath carries out one add or AND operation for each request that the
// instruction decoder presents. The operands stand on the inputs in the cycle of the
// request: the addressed memory byte on mem_rdata and the immediate byte on imm_data.
// Every result lands on the clock edge that takes the request.

// Memory-target operations raise mem_we for exactly one cycle with the result on
// mem_wdata. The controller spends that cycle in a write stage and refuses any request
// offered there. A following operation on the same byte therefore never reads a stale
// operand while the memory is still being written.

// The register-target AND forms need no write stage and may follow each other on
// consecutive cycles. Their result goes straight into the working register.

// The core may also load the working register for instructions outside this slice.
// When an operation is taken in the same cycle, the operation wins and the load is
// dropped. The decoder must not issue both at once if it needs the load.

// Each status flag is a flip-flop of its own. The add updates all four from its sum,
// the AND forms update only the zero flag, and the empty operation code is accepted
// without changing anything.

// The memory write data holds the last result between writes, so a memory that
// latches late still sees a stable value. Only mem_we marks a valid write.

// The operand width is a parameter for reuse, but the flag logic assumes a nibble
// boundary at the package's nibble width, so widths below that are not supported.

// Overview of operation
// RULE_01 - Add-to-memory writes working register plus memory byte back to memory.
// RULE_02 - Add-to-memory updates signed range, zero, half carry and carry flags.
// RULE_03 - AND memory into working register; only zero flag changes.
// RULE_04 - AND immediate into working register; only zero flag changes.
// RULE_05 - AND working register into memory; working register unchanged.
// RULE_06 - AND into memory sets zero flag from result; other flags kept.
module alud_datapath #(
    parameter int DATA_W = alud_pkg::ALUD_DATA_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic op_valid,
    input wire alud_pkg::alud_op_type op_code,
    input wire logic [DATA_W-1:0] mem_rdata,
    input wire logic [DATA_W-1:0] imm_data,
    input wire logic work_load,
    input wire logic [DATA_W-1:0] work_load_data,
    output logic op_ready,
    output logic mem_we,
    output logic [DATA_W-1:0] mem_wdata,
    output logic [DATA_W-1:0] working_register,
    output logic carry_flag,
    output logic half_carry_flag,
    output logic zero_flag,
    output logic signed_range_flag
);

    ////////////////////////////////////////////////////////////////////////////

    // Adds two bytes and returns the sum with carry out of the top bit.
    function automatic logic [DATA_W:0] alud_add(input logic [DATA_W-1:0] a,
                                                 input logic [DATA_W-1:0] b);
        alud_add = {1'b0, a} + {1'b0, b};
    endfunction

    // Reports an all-zero result.
    function automatic logic alud_is_zero(input logic [DATA_W-1:0] v);
        alud_is_zero = (v == '0);
    endfunction

    // Tells whether an operation writes its result back to data memory.
    function automatic logic alud_is_mem_target(input alud_pkg::alud_op_type code);
        alud_is_mem_target = (code == alud_pkg::ALUD_OP_ADD_MEM) ||
                             (code == alud_pkg::ALUD_OP_AND_MEM);
    endfunction

    // Signed overflow of an add: the operands share a sign that the sum lacks.
    function automatic logic alud_overflow(input logic a_sign,
                                           input logic b_sign,
                                           input logic sum_sign);
        alud_overflow = (a_sign == b_sign) && (sum_sign != a_sign);
    endfunction

    alud_pkg::alud_state_type state;
    logic [DATA_W:0] sum_full;
    logic [alud_pkg::ALUD_NIBBLE_W:0] sum_low;
    logic [DATA_W-1:0] and_mem;
    logic [DATA_W-1:0] and_imm;
    logic take;
    logic take_add;
    logic take_and_acc_mem;
    logic take_and_acc_imm;
    logic take_and_mem;
    logic take_mem_target;

    // Operand arithmetic shared by all operations.
    assign sum_full = alud_add(working_register, mem_rdata);
    assign sum_low = {1'b0, working_register[alud_pkg::ALUD_NIBBLE_W-1:0]}
                   + {1'b0, mem_rdata[alud_pkg::ALUD_NIBBLE_W-1:0]};
    assign and_mem = working_register & mem_rdata;
    assign and_imm = working_register & imm_data;

    // An operation is accepted in idle; the memory write stage blocks the next one.
    assign op_ready = (state == alud_pkg::ALUD_ST_IDLE);
    assign take = op_valid && op_ready;

    // One strobe per operation taken on this edge, at most one high; take_mem_target also rises with take_add or take_and_mem.
    assign take_add = take && (op_code == alud_pkg::ALUD_OP_ADD_MEM);
    assign take_and_acc_mem = take && (op_code == alud_pkg::ALUD_OP_AND_ACC_MEM);
    assign take_and_acc_imm = take && (op_code == alud_pkg::ALUD_OP_AND_ACC_IMM);
    assign take_and_mem = take && (op_code == alud_pkg::ALUD_OP_AND_MEM);
    assign take_mem_target = take && alud_is_mem_target(op_code);

    ////////////////////////////////////////////////////////////////////////////

    // Two-state controller: memory results are presented for one write cycle.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= alud_pkg::ALUD_ST_IDLE;
        end else begin
            case (state)
                alud_pkg::ALUD_ST_IDLE: begin
                    // A memory-target operation needs one cycle to write back.
                    if (take_mem_target) begin
                        state <= alud_pkg::ALUD_ST_WRITE;
                    end
                end
                alud_pkg::ALUD_ST_WRITE: begin
                    state <= alud_pkg::ALUD_ST_IDLE;
                end
                default: begin
                    state <= alud_pkg::ALUD_ST_IDLE;
                end
            endcase
        end
    end

    // Memory write strobe: high for exactly the write cycle of a memory-target operation.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mem_we <= 1'b0;
        end else begin
            mem_we <= take_mem_target; // [RULE_01] [RULE_05]
        end
    end

    // Memory write data: holds the last result so that a slow memory sees it stable.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mem_wdata <= alud_pkg::ALUD_MEM_WDATA_RESET;
        end else if (take_add) begin
            mem_wdata <= sum_full[DATA_W-1:0]; // [RULE_01]
        end else if (take_and_mem) begin
            mem_wdata <= and_mem; // [RULE_05]
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Working register: loaded by the AND forms that target it, else by the core.
    // A taken operation wins over a core load in the same cycle; the load is dropped.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            working_register <= alud_pkg::ALUD_WORK_RESET;
        end else if (take_and_acc_mem) begin
            working_register <= and_mem; // [RULE_03]
        end else if (take_and_acc_imm) begin
            working_register <= and_imm; // [RULE_04]
        end else if (work_load && !take) begin
            working_register <= work_load_data; // [RULE_01] [RULE_05]
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Carry flag: carry out of the top bit, changed by the add alone.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            carry_flag <= alud_pkg::ALUD_FLAGS_RESET[alud_pkg::ALUD_FLAG_CARRY];
        end else if (take_add) begin
            carry_flag <= sum_full[DATA_W]; // [RULE_02]
        end
    end

    // Half carry flag: carry out of the low nibble, changed by the add alone.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            half_carry_flag <= alud_pkg::ALUD_FLAGS_RESET[alud_pkg::ALUD_FLAG_HALF];
        end else if (take_add) begin
            half_carry_flag <= sum_low[alud_pkg::ALUD_NIBBLE_W]; // [RULE_02]
        end
    end

    // Signed range flag: overflow of the signed add.
    // The AND forms keep it, as they keep the carry and half carry flags.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            signed_range_flag <= alud_pkg::ALUD_FLAGS_RESET[alud_pkg::ALUD_FLAG_RANGE];
        end else if (take_add) begin
            signed_range_flag <= alud_overflow(working_register[DATA_W-1], mem_rdata[DATA_W-1],
                                               sum_full[DATA_W-1]); // [RULE_02]
        end
    end

    // Zero flag follows the result of every operation that produces one.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            zero_flag <= alud_pkg::ALUD_FLAGS_RESET[alud_pkg::ALUD_FLAG_ZERO];
        end else if (take_add) begin
            zero_flag <= alud_is_zero(sum_full[DATA_W-1:0]); // [RULE_02]
        end else if (take_and_acc_mem) begin
            zero_flag <= alud_is_zero(and_mem); // [RULE_03]
        end else if (take_and_acc_imm) begin
            zero_flag <= alud_is_zero(and_imm); // [RULE_04]
        end else if (take_and_mem) begin
            zero_flag <= alud_is_zero(and_mem); // [RULE_06]
        end
    end

endmodule

/* shared/alud_pkg.sv */
// Package with operation codes, flag positions and reset values for the add and logic datapath.
package alud_pkg;

    // Operation selector presented by the instruction decoder.
    typedef enum logic [2:0] {
        ALUD_OP_NONE = 3'h0,
        ALUD_OP_ADD_MEM = 3'h1,
        ALUD_OP_AND_ACC_MEM = 3'h2,
        ALUD_OP_AND_ACC_IMM = 3'h3,
        ALUD_OP_AND_MEM = 3'h4
    } alud_op_type;

    // Datapath width and status flag positions within the flag vector.
    localparam int ALUD_DATA_W = 8;
    localparam int ALUD_NIBBLE_W = 4;
    localparam int ALUD_FLAG_CARRY = 0;
    localparam int ALUD_FLAG_HALF = 1;
    localparam int ALUD_FLAG_ZERO = 2;
    localparam int ALUD_FLAG_RANGE = 3;
    localparam int ALUD_FLAG_W = 4;

    // Reset values of the working register, flags and memory write port.
    localparam logic [7:0] ALUD_WORK_RESET = 8'h00;
    localparam logic [3:0] ALUD_FLAGS_RESET = 4'h0;
    localparam logic [7:0] ALUD_MEM_WDATA_RESET = 8'h00;

    // Controller states, one-hot.
    typedef enum logic [1:0] {
        ALUD_ST_IDLE = 2'b01,
        ALUD_ST_WRITE = 2'b10
    } alud_state_type;

endpackage

/* verification/alud_datapath_chk.sv */
// Checker of datapath results and flags against the operation taken.
module alud_datapath_chk (
    input logic clk,
    input logic resetn,
    input logic op_valid,
    input alud_pkg::alud_op_type op_code,
    input logic [7:0] mem_rdata,
    input logic [7:0] imm_data,
    input logic op_ready,
    input logic mem_we,
    input logic [7:0] mem_wdata,
    input logic [7:0] working_register,
    input logic carry_flag,
    input logic half_carry_flag,
    input logic zero_flag,
    input logic signed_range_flag
);
    logic [7:0] pw;
    logic [7:0] pm;
    logic [7:0] pi;
    logic [2:0] po;
    // Operands of the previous cycle, used to judge results one cycle on.
    always_ff @(posedge clk) begin
        pw <= working_register;
        pm <= mem_rdata;
        pi <= imm_data;
        po <= {carry_flag, half_carry_flag, signed_range_flag};
    end
    // Reference sums and products of the previous operands.
    wire [8:0] s = pw + pm;
    wire [4:0] h = pw[3:0] + pm[3:0];
    wire [7:0] a = pw & pm;
    wire t = op_valid && op_ready;
    wire keep = po == {carry_flag, half_carry_flag, signed_range_flag};
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_add_mem_sum: assert property (t && op_code == alud_pkg::ALUD_OP_ADD_MEM |=>
        mem_we && mem_wdata == s[7:0] && working_register == pw) else $error("add sum wrong");
    a_add_flag_set: assert property (t && op_code == alud_pkg::ALUD_OP_ADD_MEM |=>
        carry_flag == s[8] && half_carry_flag == h[4] && zero_flag == (s[7:0] == 8'h00)
        && signed_range_flag == (pw[7] == pm[7] && s[7] != pw[7])) else $error("add flags wrong");
    a_and_acc_mem: assert property (t && op_code == alud_pkg::ALUD_OP_AND_ACC_MEM |=>
        !mem_we && working_register == a && zero_flag == (a == 8'h00) && keep)
        else $error("and memory to work wrong");
    a_and_acc_imm: assert property (t && op_code == alud_pkg::ALUD_OP_AND_ACC_IMM |=>
        !mem_we && working_register == (pw & pi) && zero_flag == ((pw & pi) == 8'h00) && keep)
        else $error("and immediate wrong");
    a_write_stage_busy: assert property (t && (op_code == alud_pkg::ALUD_OP_ADD_MEM ||
        op_code == alud_pkg::ALUD_OP_AND_MEM) |=> !op_ready ##1 op_ready && !mem_we)
        else $error("write stage handshake wrong");
    a_and_mem_write: assert property (t && op_code == alud_pkg::ALUD_OP_AND_MEM |=>
        mem_we && mem_wdata == a && working_register == pw) else $error("and to memory wrong");
    a_and_mem_flags: assert property (t && op_code == alud_pkg::ALUD_OP_AND_MEM |=>
        zero_flag == (a == 8'h00) && keep) else $error("and to memory flags wrong");
endmodule

bind alud_datapath alud_datapath_chk alud_datapath_chk_inst (.clk, .resetn, .op_valid, .op_code,
    .mem_rdata, .imm_data, .op_ready, .mem_we, .mem_wdata, .working_register, .carry_flag,
    .half_carry_flag, .zero_flag, .signed_range_flag);

/* verification/alud_datapath_bench.sv */
// Testbench running add and AND operations through the datapath.
module alud_datapath_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, resetn = 0, op_valid = 0, work_load = 0, mem_we, op_ready;
    alud_pkg::alud_op_type op_code = alud_pkg::ALUD_OP_NONE;
    logic [7:0] mem_rdata = 8'h00, imm_data = 8'h00, work_load_data = 8'h00;
    logic [7:0] mem_wdata, working_register, w = 8'h00, d = 8'h00;
    logic carry_flag, half_carry_flag, zero_flag, signed_range_flag;
    logic [3:0] f = 4'h0;
    int num_errors = 0, num_checks = 0, cyc = 0;
    alud_datapath alud_datapath_inst (.clk, .resetn, .op_valid, .op_code, .mem_rdata, .imm_data,
        .work_load, .work_load_data, .op_ready, .mem_we, .mem_wdata, .working_register,
        .carry_flag, .half_carry_flag, .zero_flag, .signed_range_flag);
    // Clock of 40 ns period and a cycle ceiling against hangs.
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            give_verdict();
        end
    end
    // Compares all outputs with the model.
    task automatic check(logic [21:0] exp);
        logic [21:0] got;
        got = {mem_we, mem_wdata, working_register, carry_flag, half_carry_flag, zero_flag,
            signed_range_flag, op_ready};
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Runs one operation, updates the model, then leaves one idle cycle.
    task automatic run_op(alud_pkg::alud_op_type code, logic [7:0] m, logic [7:0] i);
        logic [8:0] s;
        logic we;
        s = w + m;
        we = code inside {alud_pkg::ALUD_OP_ADD_MEM, alud_pkg::ALUD_OP_AND_MEM};
        if (code == alud_pkg::ALUD_OP_ADD_MEM) begin
            d = s[7:0];
            f = {s[8], (w[3:0] + m[3:0]) > 5'h0f, s[7:0] == 8'h00, w[7] == m[7] && s[7] != w[7]};
        end else begin
            d = (code == alud_pkg::ALUD_OP_AND_MEM) ? w & m : d;
            w = (code == alud_pkg::ALUD_OP_AND_MEM) ? w : w & (code[0] ? i : m);
            f[1] = ((code == alud_pkg::ALUD_OP_AND_MEM) ? d : w) == 8'h00;
        end
        op_valid = 1'b1;
        op_code = code;
        mem_rdata = m;
        imm_data = i;
        @(posedge clk) #1;
        op_valid = 0;
        check({we, d, w, f, !we});
        @(posedge clk) #1;
    endtask
    // Loads the working register from outside.
    task automatic load(logic [7:0] v);
        {work_load, work_load_data, w} = {1'b1, v, v};
        @(posedge clk) #1;
        work_load = 0;
    endtask
    // Overflow, half carry, carry and zero cases of the add.
    task automatic add_cases();
        load(8'h7f);
        run_op(alud_pkg::ALUD_OP_ADD_MEM, 8'h01, 8'h00);
        run_op(alud_pkg::ALUD_OP_ADD_MEM, 8'h81, 8'h00);
        load(8'h80);
        run_op(alud_pkg::ALUD_OP_ADD_MEM, 8'h80, 8'h00);
    endtask
    // The three AND forms: AND into memory with and without a zero result, AND memory into register nonzero, AND immediate zero.
    task automatic and_cases();
        load(8'hf0);
        run_op(alud_pkg::ALUD_OP_AND_ACC_MEM, 8'h3c, 8'hff);
        run_op(alud_pkg::ALUD_OP_AND_ACC_IMM, 8'hff, 8'h0f);
        load(8'h5a);
        run_op(alud_pkg::ALUD_OP_AND_MEM, 8'h0f, 8'h00);
        run_op(alud_pkg::ALUD_OP_AND_MEM, 8'ha5, 8'h00);
    endtask
    // A request held into the write cycle is refused, a taken request beats a core
    // load, and the empty operation changes nothing.
    task automatic busy_cases();
        load(8'h33);
        op_valid = 1'b1;
        op_code = alud_pkg::ALUD_OP_AND_MEM;
        mem_rdata = 8'h0f;
        imm_data = 8'h00;
        d = w & mem_rdata;
        f[1] = d == 8'h00;
        @(posedge clk) #1;
        check({1'b1, d, w, f, 1'b0});
        op_code = alud_pkg::ALUD_OP_AND_ACC_IMM;
        @(posedge clk) #1;
        check({1'b0, d, w, f, 1'b1});
        imm_data = 8'h0f;
        work_load = 1'b1;
        work_load_data = 8'h44;
        w = w & imm_data;
        f[1] = w == 8'h00;
        @(posedge clk) #1;
        check({1'b0, d, w, f, 1'b1});
        op_code = alud_pkg::ALUD_OP_NONE;
        work_load = 1'b0;
        @(posedge clk) #1;
        op_valid = 1'b0;
        check({1'b0, d, w, f, 1'b1});
        @(posedge clk) #1;
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Reset for ten cycles, then the scenarios.
    initial begin
        repeat (10) @(posedge clk);
        #1;
        resetn = 1;
        check(22'h00_0001);
        add_cases();
        and_cases();
        busy_cases();
        give_verdict();
    end
endmodule
